// ### serial_rx_dma_channel.sv
// One DMA channel moving received serial bytes into memory.
// Assumes an Avalon-MM register master and an Avalon-style memory port.
// Function
// - Transfers start only while the transfer go bit is one.
// - Spacing bit one inserts one idle cycle before the next trigger.
// - Escape flag sets when an escape end request is issued.
// - End flag sets when the counter issues the transfer end request.
// - Both flags clear only on a written zero; a written one does nothing.
// - Access size 01 moves one byte per transfer.
// - Transfer mode 00 is normal transfer mode.
// - Escape request forwarded only while escape enable is one.
// - End request forwarded only while end enable is one.
// - Activation factor 10 starts transfers on a peripheral interrupt.
// - Acknowledge bit one clears the selected source flag on transfer.
// - Address mode bit selects dual (0) or single (1) address mode.
// - Source update 10 increments the source address per transfer.
// - Destination update 10 increments the destination per transfer in dual address mode.
// - Request select picks the trigger; 145 is serial receive full.
// - Source address register holds the read address.
// - Destination address register holds the write address.
// - Transfer count register holds the total left to move.
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
`include "serial_rx_dma_cfg.svh"

module serial_rx_dma_channel
  import serial_rx_dma_pkg::*;
#(
  parameter int TRIG_N = 256
)
(
  input wire logic clk_sys_in, // 20 MHz system clock
  input wire logic resetn_in, // Synchronous reset, active low
  input wire logic [25:0] avs_address_in, // Register byte address
  input wire logic avs_read_in, // Register read
  input wire logic avs_write_in, // Register write
  input wire logic [31:0] avs_writedata_in, // Register write data
  input wire logic [3:0] avs_byteenable_in, // Register byte lanes
  output logic [31:0] avs_readdata_out, // Register read data
  output logic avs_waitrequest_out, // Register stall
  input wire logic [TRIG_N-1:0] trig_in, // Peripheral interrupt levels
  output logic src_flag_clr_out, // Clear pulse for selected flag
  output logic [7:0] src_flag_sel_out, // Which source flag to clear
  output mem_req_t mem_req_out, // Memory access request
  input wire logic [31:0] mem_readdata_in, // Memory read data
  input wire logic mem_waitrequest_in, // Memory stall
  output logic end_irq_out, // Transfer end interrupt
  output logic escape_irq_out, // Transfer escape interrupt
  output logic busy_out // Transfer in progress
);

  // ==========================================
  // State
  st_t s_reg;
  st_t s_next;
  logic [31:0] wmask;
  logic [31:0] rd_val;
  logic [31:0] wr_val;
  logic [31:0] step;
  logic bus_wr;
  logic start;
  logic done;
  logic end_evt;
  logic esc_evt;
  logic esc_clr;
  logic end_clr;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_lane
      assign wmask[8*gi +: 8] = {8{avs_byteenable_in[gi]}};
    end
  endgenerate

  function automatic logic [31:0] upd(
    input logic [31:0] a,
    input logic [1:0] m,
    input logic [31:0] st
  );
    case (m)
      `UPD_INC: upd = a + st;
      `UPD_DEC: upd = a - st;
      default: upd = a;
    endcase
  endfunction

  function automatic logic hit(input logic [25:0] a, input logic [23:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction

  // ==========================================
  // Next state
  always_comb
  begin
    s_next = s_reg;
    start = 1'b0;
    done = 1'b0;
    end_evt = 1'b0;
    esc_evt = 1'b0;
    esc_clr = 1'b0;
    end_clr = 1'b0;
    rd_val = 32'h00000000;
    wr_val = 32'h00000000;
    s_next.flag_clr = 1'b0;
    // Byte lane step from access size; 00 is treated as byte.
    case (s_reg.mode[`F_ACC_SIZE])
      `SIZE_WORD: step = `STEP_WORD;
      `SIZE_LONG: step = `STEP_LONG;
      default: step = `STEP_BYTE;
    endcase

    // Unmapped addresses read zero and ignore writes
    if (hit(avs_address_in, `IDX_SRC_ADDR))
      rd_val = s_reg.src;
    else if (hit(avs_address_in, `IDX_DST_ADDR))
      rd_val = s_reg.dst;
    else if (hit(avs_address_in, `IDX_XFER_CNT))
      rd_val = s_reg.cnt;
    else if (hit(avs_address_in, `IDX_MODE_CTL))
      rd_val = s_reg.mode;
    else if (hit(avs_address_in, `IDX_ADDR_CTL))
      rd_val = s_reg.actl;
    else if (hit(avs_address_in, `IDX_REQ_SEL))
      rd_val = {24'h000000, s_reg.rsel};
    wr_val = (rd_val & ~wmask) | (avs_writedata_in & wmask);

    // One wait cycle per access; the action lands on the released edge.
    if (s_reg.waitreq)
    begin
      if (avs_read_in || avs_write_in)
      begin
        s_next.waitreq = 1'b0;
        s_next.rdata = rd_val;
      end
    end
    else
    begin
      s_next.waitreq = 1'b1;
    end
    bus_wr = avs_write_in && !s_reg.waitreq;

    if (bus_wr)
    begin
      if (hit(avs_address_in, `IDX_SRC_ADDR))
        s_next.src = wr_val;
      else if (hit(avs_address_in, `IDX_DST_ADDR))
        s_next.dst = wr_val;
      else if (hit(avs_address_in, `IDX_XFER_CNT))
        s_next.cnt = wr_val;
      else if (hit(avs_address_in, `IDX_ADDR_CTL))
        s_next.actl = wr_val & `ACTL_RW_MASK;
      else if (hit(avs_address_in, `IDX_REQ_SEL))
        s_next.rsel = wr_val[7:0];
      else if (hit(avs_address_in, `IDX_MODE_CTL))
      begin
        s_next.mode = (wr_val & `MODE_RW_MASK) | (s_reg.mode & ~`MODE_RW_MASK);
        esc_clr = avs_byteenable_in[2] && !avs_writedata_in[`B_ESC_FLAG];
        end_clr = avs_byteenable_in[2] && !avs_writedata_in[`B_END_FLAG];
        // Dropping go on an unfinished job is an escape end
        if (s_reg.mode[`B_XFER_GO] && !s_next.mode[`B_XFER_GO] && s_reg.cnt != 32'h00000000)
          esc_evt = 1'b1;
      end
    end

    // ==========================================
    // Transfer engine; only normal mode exists here
    case (s_reg.fsm)
      IDLE:
      begin
        if (s_reg.mode[`B_XFER_GO] && s_reg.mode[`F_ACT_FACTOR] == `FACTOR_PERIPH
            && trig_in[s_reg.rsel] && s_reg.cnt != 32'h00000000)
        begin
          start = 1'b1;
          s_next.fsm = RD;
          s_next.mem.read = 1'b1;
          s_next.mem.address = s_reg.src;
          s_next.mem.size = s_reg.mode[`F_ACC_SIZE];
          s_next.mem.single = s_reg.actl[`B_ADDR_MODE];
          // Clear at start so the level is gone before the next acceptance
          s_next.flag_clr = s_reg.mode[`B_SRC_ACK];
        end
      end
      RD:
      begin
        if (!mem_waitrequest_in)
        begin
          s_next.mem.read = 1'b0;
          s_next.mdata = mem_readdata_in;
          if (s_reg.mem.single)
          begin
            done = 1'b1;
          end
          else
          begin
            s_next.fsm = WR;
            s_next.mem.write = 1'b1;
            s_next.mem.address = s_reg.dst;
            s_next.mem.writedata = mem_readdata_in;
          end
        end
      end
      WR:
      begin
        if (!mem_waitrequest_in)
        begin
          s_next.mem.write = 1'b0;
          done = 1'b1;
        end
      end
      GAP:
      begin
        s_next.fsm = IDLE;
      end
      default:
      begin
        s_next.fsm = IDLE;
      end
    endcase

    if (done)
    begin
      s_next.fsm = s_reg.mode[`B_REQ_SPACING] ? GAP : IDLE;
      s_next.src = upd(s_reg.src, s_reg.actl[`F_SRC_UPD], step);
      if (!s_reg.mem.single)
        s_next.dst = upd(s_reg.dst, s_reg.actl[`F_DST_UPD], step);
      s_next.cnt = s_reg.cnt - 32'h00000001;
      if (s_reg.cnt == 32'h00000001)
      begin
        end_evt = 1'b1;
        s_next.mode[`B_XFER_GO] = 1'b0;
      end
    end

    // Set wins over a clear in the same cycle
    s_next.mode[`B_END_FLAG] = (s_reg.mode[`B_END_FLAG] && !end_clr) || end_evt;
    s_next.mode[`B_ESC_FLAG] = (s_reg.mode[`B_ESC_FLAG] && !esc_clr) || esc_evt;
    s_next.end_irq = s_next.mode[`B_END_FLAG] && s_next.mode[`B_END_EN];
    s_next.esc_irq = s_next.mode[`B_ESC_FLAG] && s_next.mode[`B_ESC_EN];
    // Registered so the status pin carries no decode after the flop
    s_next.busy = (s_next.fsm != IDLE);
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      s_reg <= '0;
      s_reg.waitreq <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ==========================================
  // Outputs, all from the state register
  assign avs_readdata_out = s_reg.rdata;
  assign avs_waitrequest_out = s_reg.waitreq;
  assign src_flag_clr_out = s_reg.flag_clr;
  assign src_flag_sel_out = s_reg.rsel;
  assign mem_req_out = s_reg.mem;
  assign end_irq_out = s_reg.end_irq;
  assign escape_irq_out = s_reg.esc_irq;
  assign busy_out = s_reg.busy;

  // ==========================================
  // Checks
  a_go_gates_start: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (s_reg.fsm == IDLE && !s_reg.mode[`B_XFER_GO]) |=> s_reg.fsm != RD)
    else $error("transfer started with go low");

  a_spacing_gap: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (done && s_reg.mode[`B_REQ_SPACING]) |=> s_reg.fsm == GAP ##1 s_reg.fsm == IDLE)
    else $error("spacing cycle missing");

  a_no_spacing: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (done && !s_reg.mode[`B_REQ_SPACING]) |=> s_reg.fsm == IDLE)
    else $error("idle not reached right after transfer");

  a_esc_flag_set: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    esc_evt |=> s_reg.mode[`B_ESC_FLAG])
    else $error("escape flag not set");

  a_end_on_zero: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (done && s_reg.cnt == 32'h00000001) |=> s_reg.mode[`B_END_FLAG] && s_reg.cnt == 32'h00000000
      && !s_reg.mode[`B_XFER_GO])
    else $error("end flag not set at count zero");

  a_flag_write_one: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (!s_reg.mode[`B_END_FLAG] && !end_evt) |=> !s_reg.mode[`B_END_FLAG])
    else $error("end flag set without event");

  a_esc_gate: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    !s_reg.mode[`B_ESC_EN] |-> !escape_irq_out)
    else $error("escape request not suppressed");

  a_end_gate: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (s_reg.mode[`B_END_FLAG] && s_reg.mode[`B_END_EN]) == end_irq_out)
    else $error("end request gating wrong");

  a_ack_clear: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    start |=> src_flag_clr_out == $past(s_reg.mode[`B_SRC_ACK]))
    else $error("source flag clear wrong");

  a_src_step: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (done && s_reg.actl[`F_SRC_UPD] == `UPD_INC && s_reg.mode[`F_ACC_SIZE] == `SIZE_BYTE)
      |=> s_reg.src == $past(s_reg.src) + 32'h00000001)
    else $error("source address not incremented");

  a_factor_gate: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (s_reg.fsm == IDLE && s_reg.mode[`F_ACT_FACTOR] != `FACTOR_PERIPH) |=> s_reg.fsm == IDLE)
    else $error("started without peripheral factor");

  // ==========================================
  // Flag, spacing, address and count checks
  a_esc_flag_hold: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (!s_reg.mode[`B_ESC_FLAG] && !esc_evt) |=> !s_reg.mode[`B_ESC_FLAG])
    else $error("escape flag set without event");

  a_end_clear: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (s_reg.mode[`B_END_FLAG] && end_clr && !end_evt) |=> !s_reg.mode[`B_END_FLAG])
    else $error("end flag not cleared by written zero");

  a_esc_clear: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (s_reg.mode[`B_ESC_FLAG] && esc_clr && !esc_evt) |=> !s_reg.mode[`B_ESC_FLAG])
    else $error("escape flag not cleared by written zero");

  a_end_keep: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (s_reg.mode[`B_END_FLAG] && !end_clr) |=> s_reg.mode[`B_END_FLAG])
    else $error("end flag lost without written zero");

  a_esc_keep: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (s_reg.mode[`B_ESC_FLAG] && !esc_clr) |=> s_reg.mode[`B_ESC_FLAG])
    else $error("escape flag lost without written zero");

  a_esc_irq_on: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (s_reg.mode[`B_ESC_FLAG] && s_reg.mode[`B_ESC_EN]) |-> escape_irq_out)
    else $error("enabled escape request not forwarded");

  a_clr_pulse: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    src_flag_clr_out |=> !src_flag_clr_out)
    else $error("source flag clear longer than one cycle");

  a_gap_no_accept: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    s_reg.fsm == GAP |=> !s_reg.mem.read)
    else $error("trigger accepted in spacing cycle");

  a_single_no_write: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    s_reg.mem.single |-> !s_reg.mem.write)
    else $error("write issued in single address mode");

  a_src_fixed: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (done && s_reg.actl[`F_SRC_UPD] != `UPD_INC && s_reg.actl[`F_SRC_UPD] != `UPD_DEC)
      |=> s_reg.src == $past(s_reg.src))
    else $error("fixed source address moved");

  a_dst_step: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (done && !s_reg.mem.single && s_reg.actl[`F_DST_UPD] == `UPD_INC && s_reg.mode[`F_ACC_SIZE] == `SIZE_BYTE)
      |=> s_reg.dst == $past(s_reg.dst) + 32'h00000001)
    else $error("destination address not incremented");

  a_read_source: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    start |=> s_reg.mem.read && s_reg.mem.address == $past(s_reg.src))
    else $error("read not issued at source address");

  a_write_dest: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (s_reg.fsm == RD && !mem_waitrequest_in && !s_reg.mem.single)
      |=> s_reg.mem.write && s_reg.mem.address == $past(s_reg.dst))
    else $error("write not issued at destination address");

  a_count_step: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (done && s_reg.cnt != 32'h00000000) |=> s_reg.cnt == $past(s_reg.cnt) - 32'h00000001)
    else $error("count not decremented per unit");

  a_idle_zero_count: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (s_reg.fsm == IDLE && s_reg.cnt == 32'h00000000) |=> s_reg.fsm == IDLE)
    else $error("transfer started with count zero");
endmodule

// ### serial_rx_dma_cfg.svh
// Offsets, field positions and codes of the serial receive DMA channel.
// Assumes byte addressing on the register bus.
`ifndef SERIAL_RX_DMA_CFG_SVH
`define SERIAL_RX_DMA_CFG_SVH
// ==========================================
// Register indices (byte address = index * 4)
`define IDX_SRC_ADDR 24'hFFFC20
`define IDX_DST_ADDR 24'hFFFC24
`define IDX_XFER_CNT 24'hFFFC2C
`define IDX_MODE_CTL 24'hFFFC34
`define IDX_ADDR_CTL 24'hFFFC38
`define IDX_REQ_SEL 24'hFFFD21
// ==========================================
// Mode control fields
`define B_XFER_GO 31
`define B_REQ_SPACING 26
`define B_ESC_FLAG 17
`define B_END_FLAG 16
`define F_ACC_SIZE 15:14
`define F_XFER_MODE 13:12
`define B_ESC_EN 9
`define B_END_EN 8
`define F_ACT_FACTOR 7:6
`define B_SRC_ACK 5
`define MODE_RW_MASK 32'h8400F3E0
// ==========================================
// Address control fields
`define B_ADDR_MODE 31
`define F_SRC_UPD 21:20
`define F_DST_UPD 17:16
`define ACTL_RW_MASK 32'h80330000
// ==========================================
// Codes
`define FACTOR_PERIPH 2'h2
`define UPD_INC 2'h2
`define UPD_DEC 2'h3
`define SIZE_BYTE 2'h1
`define SIZE_WORD 2'h2
`define SIZE_LONG 2'h3
`define MODE_NORMAL 2'h0
`define REQ_SERIAL_RX0 8'h91
`define STEP_BYTE 32'h00000001
`define STEP_WORD 32'h00000002
`define STEP_LONG 32'h00000004
`endif

// ### serial_rx_dma_pkg.sv
// Types shared by the serial receive DMA channel.
// Assumes the cfg header for all numeric constants.
package serial_rx_dma_pkg;
  typedef enum logic [1:0] {IDLE, RD, WR, GAP} fsm_t;
  typedef struct packed {
    logic read;
    logic write;
    logic [31:0] address;
    logic [31:0] writedata;
    logic [1:0] size;
    logic single;
  } mem_req_t;
  typedef struct packed {
    fsm_t fsm;
    logic [31:0] src;
    logic [31:0] dst;
    logic [31:0] cnt;
    logic [31:0] mode;
    logic [31:0] actl;
    logic [7:0] rsel;
    logic waitreq;
    logic [31:0] rdata;
    mem_req_t mem;
    logic [31:0] mdata;
    logic flag_clr;
    logic end_irq;
    logic esc_irq;
    logic busy;
  } st_t;
endpackage

// ### rx_mem_model.sv
// Far-side model: byte memory with stall control and the serial receiver.
// Assumes one clock shared with the channel.
`timescale 1ns/1ps
module rx_mem_model
  import serial_rx_dma_pkg::*;
(
  input wire logic clk_in, // System clock
  input wire logic resetn_in, // Reset, active low
  input mem_req_t req_in, // Memory request
  output logic [31:0] rdata_out, // Read data
  output logic waitreq_out, // Stall
  input wire logic [3:0] delay_in, // Cycles before answer
  input wire logic push_in, // Byte received
  input wire logic [7:0] push_data_in, // Received byte
  input wire logic clr_in, // Flag clear pulse
  input wire logic [7:0] sel_in, // Flag selected
  output logic [255:0] trig_out // Interrupt levels
);
  logic [7:0] mem [32];
  logic [7:0] hold;
  logic full;
  logic ack;
  logic [3:0] cnt;
  logic [31:0] rd;
  int wr_cnt;
  // Stale data inverted so a late sample never matches
  assign rdata_out = ack ? rd : ~rd;
  assign waitreq_out = !ack;
  always_comb
  begin
    trig_out = '0;
    trig_out[145] = full;
  end
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      ack <= 1'b0;
      cnt <= 4'h0;
      full <= 1'b0;
      rd <= 32'h0;
      wr_cnt <= 0;
    end
    else
    begin
      if (push_in)
      begin
        full <= 1'b1;
        hold <= push_data_in;
      end
      else if (clr_in && sel_in == 8'h91)
        full <= 1'b0;
      if (ack)
      begin
        ack <= 1'b0;
        if (req_in.write)
        begin
          mem[req_in.address[4:0]] <= req_in.writedata[7:0];
          wr_cnt <= wr_cnt + 1;
        end
      end
      else if (req_in.read || req_in.write)
      begin
        if (cnt == delay_in)
        begin
          ack <= 1'b1;
          cnt <= 4'h0;
          rd <= {24'h0, (req_in.address == 32'h100) ? hold : mem[req_in.address[4:0]]};
        end
        else
          cnt <= cnt + 4'h1;
      end
    end
  end
endmodule

// ### serial_rx_dma_channel_tb.sv
// Self-checking bench for the serial receive DMA channel.
// Assumes the far-side model for memory and the serial receiver.
`timescale 1ns/1ps
`include "serial_rx_dma_cfg.svh"
module serial_rx_dma_channel_tb
  import serial_rx_dma_pkg::*;
;
  logic clk_sys = 0;
  logic resetn = 0;
  logic [25:0] addr = '0;
  logic rd = 0;
  logic wr = 0;
  logic [31:0] wdata = '0;
  logic [31:0] rdata;
  logic waitreq;
  logic [255:0] trig;
  logic clr;
  logic [7:0] sel;
  mem_req_t mreq;
  logic [31:0] mrdata;
  logic mwait;
  logic end_irq;
  logic esc_irq;
  logic busy;
  logic [3:0] delay = 4'h0;
  logic push = 0;
  logic [7:0] pdata = 8'h0;
  int mismatches = 0;
  int checks = 0;
  always #25 clk_sys = ~clk_sys;
  serial_rx_dma_channel i_serial_rx_dma_channel (.clk_sys_in(clk_sys), .resetn_in(resetn),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
    .trig_in(trig), .src_flag_clr_out(clr), .src_flag_sel_out(sel), .mem_req_out(mreq),
    .mem_readdata_in(mrdata), .mem_waitrequest_in(mwait), .end_irq_out(end_irq),
    .escape_irq_out(esc_irq), .busy_out(busy));
  rx_mem_model i_rx_mem_model (.clk_in(clk_sys), .resetn_in(resetn), .req_in(mreq),
    .rdata_out(mrdata), .waitreq_out(mwait), .delay_in(delay), .push_in(push),
    .push_data_in(pdata), .clr_in(clr), .sel_in(sel), .trig_out(trig));
  // ==========================================
  // Shared tasks
  task complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is sampled low
  task bus(input logic w, input logic [23:0] idx, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    addr <= {idx, 2'b00};
    wr <= w;
    rd <= !w;
    wdata <= d;
    do
      @(posedge clk_sys);
    while (waitreq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task wreg(input logic [23:0] idx, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask
  task rchk(input logic [23:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 32'h0, q);
    check(q, exp);
  endtask
  task wait_idle();
    int n;
    n = 0;
    repeat (4) @(posedge clk_sys);
    while (busy !== 1'b0 && n < 200)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 200)
    begin
      mismatches++;
      $display("[FAIL] %0t engine stayed busy", $time);
    end
  endtask
  task rx_byte(input logic [7:0] b);
    @(posedge clk_sys);
    push <= 1'b1;
    pdata <= b;
    @(posedge clk_sys);
    push <= 1'b0;
    wait_idle();
  endtask
  // ==========================================
  // Scenarios
  task t_regs();
    rchk(`IDX_MODE_CTL, 32'h0);
    rchk(24'hFFFC30, 32'h0);
    wreg(`IDX_MODE_CTL, 32'hFFFFFFFF);
    rchk(`IDX_MODE_CTL, 32'h8400F3E0);
    wreg(`IDX_MODE_CTL, 32'h0);
    wreg(`IDX_SRC_ADDR, 32'hFFFFFFFF);
    rchk(`IDX_SRC_ADDR, 32'hFFFFFFFF);
    wreg(`IDX_DST_ADDR, 32'hFFFFFFFF);
    rchk(`IDX_DST_ADDR, 32'hFFFFFFFF);
    wreg(`IDX_XFER_CNT, 32'hFFFFFFFF);
    rchk(`IDX_XFER_CNT, 32'hFFFFFFFF);
    wreg(`IDX_ADDR_CTL, 32'hFFFFFFFF);
    rchk(`IDX_ADDR_CTL, 32'h80330000);
    wreg(`IDX_REQ_SEL, 32'hFFFFFFFF);
    rchk(`IDX_REQ_SEL, 32'h000000FF);
    $display("register test done");
  endtask
  task t_xfer();
    wreg(`IDX_SRC_ADDR, 32'h100);
    wreg(`IDX_DST_ADDR, 32'h10);
    wreg(`IDX_XFER_CNT, 32'h2);
    wreg(`IDX_ADDR_CTL, 32'h00020000);
    wreg(`IDX_REQ_SEL, 32'h91);
    wreg(`IDX_MODE_CTL, 32'h800041A0);
    delay <= 4'h3;
    rx_byte(8'h5A);
    delay <= 4'h0;
    rx_byte(8'hC3);
    check(i_rx_mem_model.mem[16], 32'h5A);
    check(i_rx_mem_model.mem[17], 32'hC3);
    check(i_rx_mem_model.full, 32'h0);
    check(end_irq, 32'h1);
    rchk(`IDX_DST_ADDR, 32'h12);
    rchk(`IDX_SRC_ADDR, 32'h100);
    rchk(`IDX_XFER_CNT, 32'h0);
    rchk(`IDX_MODE_CTL, 32'h000141A0);
    wreg(`IDX_MODE_CTL, 32'h000141A0);
    rchk(`IDX_MODE_CTL, 32'h000141A0);
    wreg(`IDX_MODE_CTL, 32'h000041A0);
    rchk(`IDX_MODE_CTL, 32'h000041A0);
    check(end_irq, 32'h0);
    $display("transfer test done");
  endtask
  task t_escape();
    wreg(`IDX_DST_ADDR, 32'h14);
    wreg(`IDX_XFER_CNT, 32'h3);
    wreg(`IDX_MODE_CTL, 32'h800042A0);
    rx_byte(8'h11);
    rchk(`IDX_XFER_CNT, 32'h2);
    check(esc_irq, 32'h0);
    wreg(`IDX_MODE_CTL, 32'h000042A0);
    rchk(`IDX_MODE_CTL, 32'h000242A0);
    check(esc_irq, 32'h1);
    check(end_irq, 32'h0);
    rx_byte(8'h22);
    rchk(`IDX_XFER_CNT, 32'h2);
    check(i_rx_mem_model.wr_cnt, 32'h3);
    wreg(`IDX_MODE_CTL, 32'h000000A0);
    // Request line updates on the edge that lands the write
    @(posedge clk_sys);
    check(esc_irq, 32'h0);
    $display("escape test done");
  endtask
  // Leaves the receiver flag set, so it runs last
  task t_single();
    wreg(`IDX_XFER_CNT, 32'h1);
    wreg(`IDX_ADDR_CTL, 32'h80200000);
    wreg(`IDX_MODE_CTL, 32'h84004080);
    wait_idle();
    check(i_rx_mem_model.wr_cnt, 32'h3);
    check(i_rx_mem_model.full, 32'h1);
    check(mreq.single, 32'h1);
    check(mreq.size, 32'h1);
    rchk(`IDX_SRC_ADDR, 32'h101);
    rchk(`IDX_XFER_CNT, 32'h0);
    rchk(`IDX_MODE_CTL, 32'h04014080);
    check(end_irq, 32'h0);
    $display("single address test done");
  endtask
  initial
  begin
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    t_regs();
    t_xfer();
    t_escape();
    t_single();
    complete_run();
  end
  // Whole run needs a few hundred cycles
  initial
  begin
    #2000000;
    mismatches++;
    complete_run();
  end
endmodule
